/* File: common/serial_consts.svh */
// serial port constants: offsets, fields, reset values, timing counts
// assumes inclusion by both ends and the baud divider
`ifndef SERIAL_CONSTS_SVH
`define SERIAL_CONSTS_SVH

// ----------------------------------------
// device register offsets (8-bit port)
// ----------------------------------------
`define OFS_STATUS_ONE    8'h10
`define OFS_STATUS_TWO    8'h14
`define OFS_DATA_BUFFER   8'h18
`define OFS_CONTROL_THREE 8'h1C
`define OFS_BIT_RATE      8'h20
`define OFS_FRAME_CTRL    8'h24

// ----------------------------------------
// device field positions
// ----------------------------------------
`define S1_TX_EMPTY   7
`define S1_TX_DONE    6
`define S1_RX_FULL    5
`define S1_FRAME_ERR  1
`define S1_PARITY_ERR 0
`define S2_BREAK      1
`define S2_RX_BUSY    0
`define C3_NINTH_RX   7
`define C3_NINTH_TX   6
`define C3_FE_IE      1
`define C3_PE_IE      0
`define FC_NINE       0
`define FC_PAR_EN     1
`define FC_PAR_ODD    2
`define BR_RATE_MASK  8'h37
`define RST_BYTE      8'h00

// ----------------------------------------
// far end register offsets (AHB-Lite)
// ----------------------------------------
`define FAR_OFS_CTRL   8'h00
`define FAR_OFS_RATE   8'h04
`define FAR_OFS_DATA   8'h08
`define FAR_OFS_STATUS 8'h0C
`define FAR_CTRL_BREAK 3

// ----------------------------------------
// timing
// ----------------------------------------
`define TICKS_PER_SLOT 13'd4
`define PD_SEL_00      13'd1
`define PD_SEL_01      13'd3
`define PD_SEL_10      13'd4
`define PD_SEL_11      13'd13
`define SLOT_MID       4'd7
`define SLOT_LAST      4'd15
`define IDLE_SLOTS     8'd160
`define RX_SH_BITS     4'd10

`endif

/* File: common/serial_line_if.sv */
// serial line between the port and the remote transceiver
// assumes both ends clocked by one common clock
`timescale 1ns/1ps
interface serial_line_if;
  logic dev_to_far;
  logic far_to_dev;
  modport device (output dev_to_far, input far_to_dev);
  modport far (output far_to_dev, input dev_to_far);
endinterface : serial_line_if

/* File: common/serial_pkg.sv */
// serial port types and frame helpers
// assumes LSB-first frames: start, data, optional parity, stop
package serial_pkg;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

  // ----------------------------------------
  // frame build
  // ----------------------------------------
  function automatic logic [11:0] build_frame(input logic [8:0] d, input logic nine, input logic par_en,
                                              input logic odd);
    logic [11:0] f;
    logic        p;
    f      = 12'hFFF;
    p      = (^d[7:0]) ^ (nine & d[8]) ^ odd;
    f[0]   = 1'b0;
    f[8:1] = d[7:0];
    if (nine) f[9] = d[8];
    if (par_en) begin
      if (nine) f[10] = p;
      else f[9] = p;
    end
    return f;
  endfunction : build_frame

  function automatic logic [3:0] frame_len(input logic nine, input logic par_en);
    return 4'hA + {3'h0, nine} + {3'h0, par_en};
  endfunction : frame_len

endpackage : serial_pkg

/* File: dv/sci_rx_status_and_baud_gen_tb.sv */
// bench joining the serial port and the far end transceiver
// assumes the far end is reached over AHB-Lite, one clock for both
`timescale 1ns/1ps
`include "serial_consts.svh"
module sci_rx_status_and_baud_gen_tb;
  logic        clk = 0, rst = 1, wr = 0, rd = 0, hw = 0, hrdy, hresp, irq;
  logic [7:0]  ad = 0, wd = 0, rdat;
  logic [1:0]  ht = 0;
  logic [31:0] ha = 0, hd = 0, hr, r;
  int          miscompares = 0, check_count = 0, n;
  serial_line_if ln();
  serial_port_device u_serial_port_device (.CLOCK_I(clk), .SRST_I(rst), .REG_ADDR_I(ad), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wd), .REG_RDATA_O(rdat), .ERR_IRQ_O(irq), .line(ln.device));
  serial_far_end u_serial_far_end (.CLOCK_I(clk), .SRST_I(rst), .HSEL_I(1'b1), .HADDR_I(ha), .HTRANS_I(ht),
    .HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(hd), .HREADY_I(hrdy), .HRDATA_O(hr), .HREADYOUT_O(hrdy),
    .HRESP_O(hresp), .line(ln.far));
  serial_checker u_serial_checker (.CLOCK_I(clk), .SRST_I(rst), .dev_to_far(ln.dev_to_far),
    .far_to_dev(ln.far_to_dev));
  always #2 clk = ~clk;
  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task ck(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask : ck
  task dw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); ad <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : dw
  task dr(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk); ad <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 ck({24'h0, rdat & m}, {24'h0, e});
  endtask : dr
  task ah(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); ht <= 2'h2; ha <= {24'h0, a}; hw <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    ht <= 2'h0; hd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hr;
    ck({31'h0, hresp}, 32'h0);
  endtask : ah
  task dp;
    repeat (9000) begin
      dr(`OFS_STATUS_ONE, 8'h00, 8'h00);
      if (rdat[`S1_RX_FULL] === 1'b1) break;
    end
  endtask : dp
  task fp;
    repeat (3000) begin
      ah(1'b0, `FAR_OFS_STATUS, 32'h0);
      if (r[1] === 1'b1) break;
    end
    ah(1'b0, `FAR_OFS_DATA, 32'h0);
  endtask : fp
  task results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    #200000;
    miscompares++;
    results;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    dr(`OFS_BIT_RATE, 8'hFF, 8'h00);
    dr(`OFS_STATUS_TWO, 8'h03, 8'h00);
    dr(8'h30, 8'hFF, 8'h00);
    $display("test reset done");
    ah(1'b1, `FAR_OFS_DATA, 32'hA5);
    dp;
    dr(`OFS_STATUS_ONE, 8'h23, 8'h20);
    dr(`OFS_DATA_BUFFER, 8'hFF, 8'hA5);
    dr(`OFS_STATUS_ONE, 8'h20, 8'h00);
    dw(`OFS_DATA_BUFFER, 8'h3C);
    fp;
    ck(r & 32'h1FF, 32'h3C);
    dr(`OFS_STATUS_ONE, 8'h80, 8'h80);
    $display("test data both ways done");
    dw(`OFS_CONTROL_THREE, 8'h02);
    ah(1'b1, `FAR_OFS_CTRL, 32'h8);
    repeat (800) @(posedge clk);
    ah(1'b1, `FAR_OFS_CTRL, 32'h0);
    repeat (100) @(posedge clk);
    #1 ck({31'h0, irq}, 32'h1);
    dr(`OFS_STATUS_TWO, 8'h02, 8'h02);
    dr(`OFS_DATA_BUFFER, 8'hFF, 8'h00);
    dr(`OFS_STATUS_TWO, 8'h02, 8'h00);
    dr(`OFS_STATUS_ONE, 8'h23, 8'h22);
    dr(`OFS_DATA_BUFFER, 8'h00, 8'h00);
    dr(`OFS_STATUS_ONE, 8'h23, 8'h00);
    @(posedge clk); #1 ck({31'h0, irq}, 32'h0);
    $display("test break done");
    dw(`OFS_FRAME_CTRL, 8'h02);
    dw(`OFS_CONTROL_THREE, 8'h01);
    ah(1'b1, `FAR_OFS_CTRL, 32'h6);
    ah(1'b1, `FAR_OFS_DATA, 32'h5A);
    dp;
    @(posedge clk); #1 ck({31'h0, irq}, 32'h1);
    dr(`OFS_STATUS_ONE, 8'h21, 8'h21);
    dr(`OFS_DATA_BUFFER, 8'hFF, 8'h5A);
    dr(`OFS_STATUS_ONE, 8'h01, 8'h00);
    $display("test parity done");
    dw(`OFS_FRAME_CTRL, 8'h00);
    ah(1'b1, `FAR_OFS_CTRL, 32'h0);
    ah(1'b1, `FAR_OFS_RATE, 32'h11);
    dw(`OFS_BIT_RATE, 8'h11);
    dr(`OFS_BIT_RATE, 8'hFF, 8'h11);
    dw(`OFS_DATA_BUFFER, 8'hC3);
    n = 0;
    while (ln.dev_to_far !== 1'b0 && n < 5000) begin @(posedge clk); n++; end
    n = 0;
    while (ln.dev_to_far === 1'b0 && n < 5000) begin @(posedge clk); n++; end
    ck(n, 32'd384);
    fp;
    ck(r & 32'h1FF, 32'hC3);
    $display("test rate done");
    dw(`OFS_FRAME_CTRL, 8'h01);
    ah(1'b1, `FAR_OFS_CTRL, 32'h1);
    ah(1'b1, `FAR_OFS_DATA, 32'h1A5);
    dp;
    dr(`OFS_CONTROL_THREE, 8'h80, 8'h80);
    dr(`OFS_DATA_BUFFER, 8'hFF, 8'hA5);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    dr(`OFS_DATA_BUFFER, 8'hFF, 8'hA5);
    dw(`OFS_FRAME_CTRL, 8'h01);
    ah(1'b1, `FAR_OFS_CTRL, 32'h9);
    repeat (800) @(posedge clk);
    dr(`OFS_CONTROL_THREE, 8'h80, 8'h00);
    dr(`OFS_STATUS_TWO, 8'h01, 8'h01);
    ah(1'b1, `FAR_OFS_CTRL, 32'h1);
    repeat (800) @(posedge clk);
    dr(`OFS_STATUS_TWO, 8'h01, 8'h00);
    dr(`OFS_STATUS_TWO, 8'h03, 8'h02);
    $display("test nine-bit and reset done");
    results;
  end
endmodule : sci_rx_status_and_baud_gen_tb

/* File: dv/serial_checker.sv */
// line checks on the serial link between the two ends
// assumes one clock, sync active-high reset, line idles high
`timescale 1ns/1ps
module serial_checker (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic dev_to_far,
  input wire logic far_to_dev
);
  // ----------------------------------------
  // run length of each line level
  // ----------------------------------------
  logic       dev_q_reg, far_q_reg;
  logic [6:0] dev_run_reg, far_run_reg;
  always_ff @(posedge CLOCK_I) begin
    dev_q_reg   <= SRST_I | dev_to_far;
    dev_run_reg <= SRST_I ? 7'd63 : (dev_to_far != dev_q_reg) ? 7'd0 : dev_run_reg + {6'h0, dev_run_reg < 7'd63};
  end
  always_ff @(posedge CLOCK_I) begin
    far_q_reg   <= SRST_I | far_to_dev;
    far_run_reg <= SRST_I ? 7'd63 : (far_to_dev != far_q_reg) ? 7'd0 : far_run_reg + {6'h0, far_run_reg < 7'd63};
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  a_tx_bit_len: assert property (dev_to_far != dev_q_reg |-> dev_run_reg >= 7'd63)
    else $error("device line bit shorter than 64 clocks");
  a_far_bit_len: assert property (far_to_dev != far_q_reg |-> far_run_reg >= 7'd63)
    else $error("far line bit shorter than 64 clocks");
  a_tx_fall_hold: assert property ($fell(dev_to_far) |=> $stable(dev_to_far)[*8])
    else $error("device line low glitch");
  a_far_fall_hold: assert property ($fell(far_to_dev) |=> $stable(far_to_dev)[*8])
    else $error("far line low glitch");
  a_tx_rise_hold: assert property ($rose(dev_to_far) |=> $stable(dev_to_far)[*8])
    else $error("device line high glitch");
  a_far_rise_hold: assert property ($rose(far_to_dev) |=> $stable(far_to_dev)[*8])
    else $error("far line high glitch");
  a_reset_idle: assert property ($fell(SRST_I) |-> dev_to_far && far_to_dev)
    else $error("line not idle after reset");
  a_idle_quiet: assert property ($fell(SRST_I) |=> (dev_to_far && far_to_dev)[*8])
    else $error("line left idle too soon");
endmodule : serial_checker

/* File: rtl/baud_tick_gen.sv */
// sample-slot enable: sixteen slots per bit
// assumes select inputs held stable between frames
`timescale 1ns/1ps
`include "serial_consts.svh"
module baud_tick_gen (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [1:0] presc_sel_i,
  input  wire logic [2:0] rate_sel_i,
  output logic            tick_o
);
  logic [12:0] pd;
  logic [12:0] limit;
  logic [12:0] cnt_reg;

  // ----------------------------------------
  // divisor: 64*pd*bd per bit, 4*pd*bd per slot
  // ----------------------------------------
  always_comb begin
    case (presc_sel_i)
      2'h0: pd = `PD_SEL_00;
      2'h1: pd = `PD_SEL_01;
      2'h2: pd = `PD_SEL_10;
      default: pd = `PD_SEL_11;
    endcase
    limit = ((pd * `TICKS_PER_SLOT) << rate_sel_i) - 13'd1;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_reg <= 13'h0;
      tick_o  <= 1'b0;
    end else if (cnt_reg >= limit) begin
      cnt_reg <= 13'h0;
      tick_o  <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 13'd1;
      tick_o  <= 1'b0;
    end
  end
endmodule : baud_tick_gen

/* File: rtl/serial_far_end.sv */
// remote transceiver on the line, commanded over AHB-Lite
// assumes a single master, whole-word transfers, same clock as the port
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_far_end (
  input  wire logic        CLOCK_I,
  input  wire logic        SRST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  serial_line_if.far       line
);
  logic                  tick, rxd;
  logic                  ph_reg, ph_wr_reg;
  logic [7:0]            ph_addr_reg;
  logic [3:0]            ctrl_reg;
  logic [5:0]            rate_reg;
  logic                  wr_data, rd_data;
  serial_pkg::tx_state_t tx_state_reg;
  logic [11:0]           tx_sh_reg;
  logic [3:0]            tx_slot_reg, tx_bits_reg;
  logic                  txd_reg;
  serial_pkg::rx_state_t rx_state_reg;
  logic [3:0]            rx_slot_reg, rx_cnt_reg, rx_n;
  logic [9:0]            rx_sh_reg, rx_word;
  logic                  seen_one_reg, rx_valid_reg, rx_ferr_reg;
  logic [8:0]            rx_data_reg;
  logic                  stop_eval;

  assign rxd       = line.dev_to_far;
  assign line.far_to_dev = txd_reg;
  assign wr_data   = ph_reg && ph_wr_reg && ph_addr_reg == `FAR_OFS_DATA;
  assign rd_data   = ph_reg && !ph_wr_reg && ph_addr_reg == `FAR_OFS_DATA;
  assign rx_n      = serial_pkg::frame_len(ctrl_reg[0], ctrl_reg[1]) - 4'd2;
  assign rx_word   = rx_sh_reg >> (`RX_SH_BITS - rx_n);
  assign stop_eval = tick && rx_state_reg == serial_pkg::RX_STOP && rx_slot_reg == `SLOT_MID;

  baud_tick_gen u_baud (
    .clk_i       (CLOCK_I),
    .srst_i      (SRST_I),
    .presc_sel_i (rate_reg[5:4]),
    .rate_sel_i  (rate_reg[2:0]),
    .tick_o      (tick)
  );

  // ----------------------------------------
  // AHB-Lite slave, one wait state per transfer
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ph_reg      <= 1'b0;
      ph_wr_reg   <= 1'b0;
      ph_addr_reg <= 8'h00;
      HREADYOUT_O <= 1'b1;
      HRDATA_O    <= 32'h00000000;
      HRESP_O     <= 1'b0;
      ctrl_reg    <= 4'h0;
      rate_reg    <= 6'h00;
    end else if (ph_reg) begin
      ph_reg      <= 1'b0;
      HREADYOUT_O <= 1'b1;
      if (ph_wr_reg && ph_addr_reg == `FAR_OFS_CTRL) ctrl_reg <= HWDATA_I[3:0];
      if (ph_wr_reg && ph_addr_reg == `FAR_OFS_RATE) rate_reg <= HWDATA_I[5:0];
      case (ph_addr_reg)
        `FAR_OFS_CTRL:   HRDATA_O <= {28'h0000000, ctrl_reg};
        `FAR_OFS_RATE:   HRDATA_O <= {26'h0000000, rate_reg};
        `FAR_OFS_DATA:   HRDATA_O <= {23'h000000, rx_data_reg};
        `FAR_OFS_STATUS: HRDATA_O <= {29'h00000000, rx_ferr_reg, rx_valid_reg,
                                      tx_state_reg == serial_pkg::TX_SHIFT};
        default:         HRDATA_O <= 32'h00000000;
      endcase
    end else if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
      ph_reg      <= 1'b1;
      ph_wr_reg   <= HWRITE_I;
      ph_addr_reg <= HADDR_I[7:0];
      HREADYOUT_O <= 1'b0;
    end
  end

  // ----------------------------------------
  // transmitter; data write ignored while busy
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_state_reg <= serial_pkg::TX_IDLE;
      tx_sh_reg    <= 12'hFFF;
      tx_slot_reg  <= 4'h0;
      tx_bits_reg  <= 4'h0;
      txd_reg      <= 1'b1;
    end else begin
      // line moves only on slot ticks so every bit is a full sixteen slots
      if (tick) txd_reg <= (tx_state_reg == serial_pkg::TX_SHIFT) ? tx_sh_reg[0] : !ctrl_reg[`FAR_CTRL_BREAK];
      if (tx_state_reg == serial_pkg::TX_IDLE) begin
        if (wr_data) begin
          tx_sh_reg    <= serial_pkg::build_frame(HWDATA_I[8:0], ctrl_reg[0], ctrl_reg[1], ctrl_reg[2]);
          tx_bits_reg  <= serial_pkg::frame_len(ctrl_reg[0], ctrl_reg[1]);
          tx_slot_reg  <= 4'h0;
          tx_state_reg <= serial_pkg::TX_SHIFT;
        end
      end else if (tick) begin
        tx_slot_reg <= tx_slot_reg + 4'd1;
        if (tx_slot_reg == `SLOT_LAST) begin
          tx_sh_reg   <= {1'b1, tx_sh_reg[11:1]};
          tx_bits_reg <= tx_bits_reg - 4'd1;
          if (tx_bits_reg == 4'd1) tx_state_reg <= serial_pkg::TX_IDLE;
        end
      end
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rx_state_reg <= serial_pkg::RX_IDLE;
      rx_slot_reg  <= 4'h0;
      rx_cnt_reg   <= 4'h0;
      rx_sh_reg    <= 10'h0;
      seen_one_reg <= 1'b0;
    end else if (tick) begin
      rx_slot_reg <= rx_slot_reg + 4'd1;
      case (rx_state_reg)
        serial_pkg::RX_IDLE: begin
          seen_one_reg <= rxd;
          if (!rxd && seen_one_reg) begin
            rx_state_reg <= serial_pkg::RX_START;
            rx_slot_reg  <= 4'd1;
          end
        end
        serial_pkg::RX_START: begin
          if (rx_slot_reg == `SLOT_MID && rxd) rx_state_reg <= serial_pkg::RX_IDLE;
          if (rx_slot_reg == `SLOT_LAST) begin
            rx_state_reg <= serial_pkg::RX_DATA;
            rx_cnt_reg   <= 4'h0;
          end
        end
        serial_pkg::RX_DATA: begin
          if (rx_slot_reg == `SLOT_MID) rx_sh_reg <= {rxd, rx_sh_reg[9:1]};
          if (rx_slot_reg == `SLOT_LAST) begin
            rx_cnt_reg <= rx_cnt_reg + 4'd1;
            if (rx_cnt_reg == rx_n - 4'd1) rx_state_reg <= serial_pkg::RX_STOP;
          end
        end
        serial_pkg::RX_STOP: begin
          if (rx_slot_reg == `SLOT_MID) begin
            rx_state_reg <= serial_pkg::RX_IDLE;
            seen_one_reg <= rxd;
          end
        end
        default: rx_state_reg <= serial_pkg::RX_IDLE;
      endcase
    end
  end

  // received word; valid set wins over read clear
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rx_data_reg  <= 9'h000;
      rx_valid_reg <= 1'b0;
      rx_ferr_reg  <= 1'b0;
    end else begin
      rx_valid_reg <= stop_eval || (rx_valid_reg && !rd_data);
      if (stop_eval) begin
        rx_data_reg <= ctrl_reg[0] ? rx_word[8:0] : {1'b0, rx_word[7:0]};
        rx_ferr_reg <= !rxd;
      end
    end
  end
endmodule : serial_far_end

/* File: rtl/serial_port_device.sv */
// serial port: receive flags, data buffer, baud generator, transmitter
// assumes software on the byte port, remote transceiver on the line
//
// Design decision made here: the byte-wide register port with separate read and write strobes.
`timescale 1ns/1ps
`include "serial_consts.svh"
module serial_port_device (
  input  wire logic       CLOCK_I,
  input  wire logic       SRST_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic [7:0]      REG_RDATA_O,
  output logic            ERR_IRQ_O,
  serial_line_if.device   line
);
  logic                 tick;
  logic [7:0]           bit_rate_reg;
  logic [2:0]           frame_reg;
  logic                 fe_ie_reg, pe_ie_reg, t8_reg;
  logic                 fe_reg, pe_reg, rf_reg, bk_reg, rpf_reg;
  logic                 arm_fe_reg, arm_pe_reg, arm_rf_reg, arm_bk_reg;
  logic [7:0]           rx_data_reg;
  logic                 rx_ninth_reg;
  logic [7:0]           tx_data_reg;
  logic                 tx_ninth_reg, tx_full_reg;
  serial_pkg::rx_state_t rx_state_reg;
  logic [3:0]           rx_slot_reg, rx_cnt_reg;
  logic [9:0]           rx_sh_reg;
  logic                 seen_one_reg, brk_armed_reg;
  logic [7:0]           idle_cnt_reg;
  serial_pkg::tx_state_t tx_state_reg;
  logic [11:0]          tx_sh_reg;
  logic [3:0]           tx_slot_reg, tx_bits_reg;
  logic                 txd_reg;
  logic                 rxd, nine, par_en, odd;
  logic                 rd_s1, rd_s2, rd_data, wr_data;
  logic [3:0]           rx_n;
  logic [9:0]           rx_word;
  logic                 stop_eval, is_break, brk_take, par_bad;

  assign rxd     = line.far_to_dev;
  assign nine    = frame_reg[`FC_NINE];
  assign par_en  = frame_reg[`FC_PAR_EN];
  assign odd     = frame_reg[`FC_PAR_ODD];
  assign rd_s1   = REG_RD_I && REG_ADDR_I == `OFS_STATUS_ONE;
  assign rd_s2   = REG_RD_I && REG_ADDR_I == `OFS_STATUS_TWO;
  assign rd_data = REG_RD_I && REG_ADDR_I == `OFS_DATA_BUFFER;
  assign wr_data = REG_WR_I && REG_ADDR_I == `OFS_DATA_BUFFER;
  assign line.dev_to_far = txd_reg;

  // ----------------------------------------
  // baud generator shared by both directions
  // ----------------------------------------
  baud_tick_gen u_baud (
    .clk_i       (CLOCK_I),
    .srst_i      (SRST_I),
    .presc_sel_i (bit_rate_reg[5:4]),
    .rate_sel_i  (bit_rate_reg[2:0]),
    .tick_o      (tick)
  );

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      bit_rate_reg <= `RST_BYTE;
      frame_reg    <= 3'h0;
      fe_ie_reg    <= 1'b0;
      pe_ie_reg    <= 1'b0;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == `OFS_BIT_RATE) bit_rate_reg <= REG_WDATA_I & `BR_RATE_MASK;
      if (REG_ADDR_I == `OFS_FRAME_CTRL) frame_reg <= REG_WDATA_I[2:0];
      if (REG_ADDR_I == `OFS_CONTROL_THREE) begin
        fe_ie_reg <= REG_WDATA_I[`C3_FE_IE];
        pe_ie_reg <= REG_WDATA_I[`C3_PE_IE];
      end
    end
  end

  // ninth transmit bit and data buffers are never reset
  always_ff @(posedge CLOCK_I) begin
    if (REG_WR_I && REG_ADDR_I == `OFS_CONTROL_THREE) t8_reg <= REG_WDATA_I[`C3_NINTH_TX];
    if (wr_data) begin
      tx_data_reg  <= REG_WDATA_I;
      tx_ninth_reg <= t8_reg;
    end
  end

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  assign rx_n      = serial_pkg::frame_len(nine, par_en) - 4'd2;
  assign rx_word   = rx_sh_reg >> (`RX_SH_BITS - rx_n);
  assign stop_eval = tick && rx_state_reg == serial_pkg::RX_STOP && rx_slot_reg == `SLOT_MID;
  assign is_break  = stop_eval && rx_word == 10'h0 && !rxd;
  assign brk_take  = is_break && brk_armed_reg;
  assign par_bad   = par_en && ((^rx_word) != odd);

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rx_state_reg  <= serial_pkg::RX_IDLE;
      rx_slot_reg   <= 4'h0;
      rx_cnt_reg    <= 4'h0;
      rx_sh_reg     <= 10'h0;
      seen_one_reg  <= 1'b0;
      brk_armed_reg <= 1'b1;
      idle_cnt_reg  <= 8'h0;
    end else if (tick) begin
      rx_slot_reg <= rx_slot_reg + 4'd1;
      if (rxd) brk_armed_reg <= 1'b1;
      else if (brk_take) brk_armed_reg <= 1'b0;
      case (rx_state_reg)
        serial_pkg::RX_IDLE: begin
          seen_one_reg <= rxd;
          idle_cnt_reg <= rxd ? ((idle_cnt_reg == `IDLE_SLOTS) ? idle_cnt_reg : idle_cnt_reg + 8'd1) : 8'h0;
          if (!rxd && seen_one_reg) begin
            rx_state_reg <= serial_pkg::RX_START;
            rx_slot_reg  <= 4'd1;
          end
        end
        serial_pkg::RX_START: begin
          if (rx_slot_reg == `SLOT_MID && rxd) rx_state_reg <= serial_pkg::RX_IDLE;
          if (rx_slot_reg == `SLOT_LAST) begin
            rx_state_reg <= serial_pkg::RX_DATA;
            rx_cnt_reg   <= 4'h0;
          end
        end
        serial_pkg::RX_DATA: begin
          if (rx_slot_reg == `SLOT_MID) rx_sh_reg <= {rxd, rx_sh_reg[9:1]};
          if (rx_slot_reg == `SLOT_LAST) begin
            rx_cnt_reg <= rx_cnt_reg + 4'd1;
            if (rx_cnt_reg == rx_n - 4'd1) rx_state_reg <= serial_pkg::RX_STOP;
          end
        end
        serial_pkg::RX_STOP: begin
          if (rx_slot_reg == `SLOT_MID) begin
            rx_state_reg <= serial_pkg::RX_IDLE;
            seen_one_reg <= rxd;
            idle_cnt_reg <= 8'h0;
          end
        end
        default: rx_state_reg <= serial_pkg::RX_IDLE;
      endcase
    end
  end

  // received byte and ninth bit move together
  always_ff @(posedge CLOCK_I) begin
    if (stop_eval) begin
      rx_data_reg  <= rx_word[7:0];
      rx_ninth_reg <= nine ? rx_word[8] : rx_word[7];
      if (is_break && nine) rx_ninth_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) rpf_reg <= 1'b0;
    else if (tick && rx_state_reg == serial_pkg::RX_IDLE && !rxd && seen_one_reg) rpf_reg <= 1'b1;
    else if (tick && rx_state_reg == serial_pkg::RX_START && rx_slot_reg == `SLOT_MID && rxd)
      rpf_reg <= 1'b0;
    else if (tick && rx_state_reg == serial_pkg::RX_IDLE && idle_cnt_reg == `IDLE_SLOTS - 8'd1)
      rpf_reg <= 1'b0;
  end

  // ----------------------------------------
  // status flags: set wins over clear
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      arm_fe_reg <= 1'b0;
      arm_pe_reg <= 1'b0;
      arm_rf_reg <= 1'b0;
      arm_bk_reg <= 1'b0;
    end else if (rd_data) begin
      arm_fe_reg <= 1'b0;
      arm_pe_reg <= 1'b0;
      arm_rf_reg <= 1'b0;
      arm_bk_reg <= 1'b0;
    end else begin
      if (rd_s1) begin
        arm_fe_reg <= fe_reg;
        arm_pe_reg <= pe_reg;
        arm_rf_reg <= rf_reg;
      end
      if (rd_s2) arm_bk_reg <= bk_reg;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      fe_reg <= 1'b0;
      pe_reg <= 1'b0;
      rf_reg <= 1'b0;
      bk_reg <= 1'b0;
    end else begin
      fe_reg <= (stop_eval && (!rxd || brk_take)) || (fe_reg && !(rd_data && arm_fe_reg));
      pe_reg <= (stop_eval && !is_break && par_bad) || (pe_reg && !(rd_data && arm_pe_reg));
      rf_reg <= stop_eval || (rf_reg && !(rd_data && arm_rf_reg));
      bk_reg <= brk_take || (bk_reg && !(rd_data && arm_bk_reg));
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_state_reg <= serial_pkg::TX_IDLE;
      tx_sh_reg    <= 12'hFFF;
      tx_slot_reg  <= 4'h0;
      tx_bits_reg  <= 4'h0;
      tx_full_reg  <= 1'b0;
      txd_reg      <= 1'b1;
    end else begin
      // line moves only on slot ticks so the start bit is never cut short
      if (tick) txd_reg <= (tx_state_reg == serial_pkg::TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
      if (wr_data) tx_full_reg <= 1'b1;
      else if (tx_state_reg == serial_pkg::TX_IDLE && tx_full_reg) tx_full_reg <= 1'b0;
      if (tx_state_reg == serial_pkg::TX_IDLE) begin
        if (tx_full_reg) begin
          tx_sh_reg    <= serial_pkg::build_frame({tx_ninth_reg, tx_data_reg}, nine, par_en, odd);
          tx_bits_reg  <= serial_pkg::frame_len(nine, par_en);
          tx_slot_reg  <= 4'h0;
          tx_state_reg <= serial_pkg::TX_SHIFT;
        end
      end else if (tick) begin
        tx_slot_reg <= tx_slot_reg + 4'd1;
        if (tx_slot_reg == `SLOT_LAST) begin
          tx_sh_reg   <= {1'b1, tx_sh_reg[11:1]};
          tx_bits_reg <= tx_bits_reg - 4'd1;
          if (tx_bits_reg == 4'd1) tx_state_reg <= serial_pkg::TX_IDLE;
        end
      end
    end
  end

  // ----------------------------------------
  // read port and interrupt
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      REG_RDATA_O <= 8'h00;
      ERR_IRQ_O   <= 1'b0;
    end else begin
      ERR_IRQ_O <= (fe_reg && fe_ie_reg) || (pe_reg && pe_ie_reg);
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          `OFS_STATUS_ONE: REG_RDATA_O <= {!tx_full_reg, !tx_full_reg && tx_state_reg == serial_pkg::TX_IDLE,
                                           rf_reg, 3'h0, fe_reg, pe_reg};
          `OFS_STATUS_TWO: REG_RDATA_O <= {6'h00, bk_reg, rpf_reg};
          `OFS_DATA_BUFFER: REG_RDATA_O <= rx_data_reg;
          `OFS_CONTROL_THREE: REG_RDATA_O <= {rx_ninth_reg, t8_reg, 4'h0, fe_ie_reg, pe_ie_reg};
          `OFS_BIT_RATE: REG_RDATA_O <= bit_rate_reg;
          `OFS_FRAME_CTRL: REG_RDATA_O <= {5'h00, frame_reg};
          default: REG_RDATA_O <= 8'h00;
        endcase
      end
    end
  end
endmodule : serial_port_device
